//--- rtl/soc_orient_regs.vh
// register map, field layout, reset values and timing counts
// assumes a 50 MHz ref clock and 32-bit APB word addressing
`ifndef SOC_ORIENT_REGS_VH
`define SOC_ORIENT_REGS_VH
`define SOC_CLK_MHZ 50
`define SOC_OFF_CTRL 8'h00
`define SOC_OFF_DIRSEL 8'h04
`define SOC_OFF_OSPEED 8'h08
`define SOC_OFF_STOPPOS 8'h0C
`define SOC_OFF_SRCSEL 8'h10
`define SOC_OFF_PGAIN 8'h14
`define SOC_OFF_DECEL 8'h18
`define SOC_OFF_ZONE 8'h1C
`define SOC_OFF_SHIFT 8'h20
`define SOC_OFF_LAGGAIN 8'h24
`define SOC_OFF_DISP 8'h28
`define SOC_OFF_SPDCMD 8'h2C
`define SOC_OFF_STATUS 8'h30
`define SOC_OFF_INTSTAT 8'h34
`define SOC_OFF_INTMASK 8'h38
`define SOC_OFF_POS 8'h3C
`define SOC_CTRL_FCLR 0
`define SOC_SRC_EXT 0
`define SOC_SRC_16B 1
`define SOC_INT_DONE 0
`define SOC_INT_FAULT 1
`define SOC_INT_ZIDX 2
`define SOC_RST_DIRSEL 2'h0
`define SOC_RST_OSPEED 16'h00C8
`define SOC_RST_DECEL 16'h0014
`define SOC_RST_PGAIN 8'h0A
`define SOC_RST_ZONE 16'h000B
`define SOC_RST_DISP 8'h00
`define SOC_DISP_POS 8'h13
`define SOC_RAMP_US 10
`define SOC_RAMP_CYC (`SOC_RAMP_US * `SOC_CLK_MHZ)
`define SOC_ENC_LOSS_US 10000
`define SOC_ENC_LOSS_CYC (`SOC_ENC_LOSS_US * `SOC_CLK_MHZ)
`endif

//--- rtl/soc_quad.v
// quadrature position counter with index reference
// assumes raw encoder pins asynchronous to ref_clk_i
`timescale 1ns/10ps
module soc_quad (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire enc_a_i,
  input wire enc_b_i,
  input wire enc_z_i,
  output reg [15:0] pos_o,
  output reg z_pulse_o,
  output reg edge_o
);
  wire [2:0] raw;
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [2:0] s3_r;
  reg [2:0] lvl_r;
  reg [2:0] lvl_nxt;
  reg [15:0] pos_nxt;
  integer k;
  assign raw = {enc_z_i, enc_b_i, enc_a_i};
  //////////////////////////////////////////////////////////////////////
  // three-stage synchronisers, change taken when stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////
  // x4 decode
  always @* begin
    lvl_nxt = lvl_r;
    for (k = 0; k < 3; k = k + 1) begin
      if (s2_r[k] == s3_r[k]) begin
        lvl_nxt[k] = s3_r[k];
      end
    end
    pos_nxt = pos_o;
    if (lvl_nxt[1:0] != lvl_r[1:0]) begin
      if ((lvl_nxt[0] ^ lvl_r[1]) == 1'b1) begin
        pos_nxt = pos_o + 16'h0001;
      end else begin
        pos_nxt = pos_o - 16'h0001;
      end
    end
    if (lvl_nxt[2] && !lvl_r[2]) begin
      pos_nxt = 16'h0000;
    end
  end
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      lvl_r <= 3'h0;
      pos_o <= 16'h0000;
      z_pulse_o <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      pos_o <= pos_nxt;
      z_pulse_o <= lvl_nxt[2] && !lvl_r[2];
      edge_o <= (lvl_nxt != lvl_r);
    end
  end
endmodule // soc_quad

//--- rtl/soc_orient.v
// spindle orientation sequencer with APB register file
// assumes APB master on ref_clk_i and external pins asynchronous
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "soc_orient_regs.vh"
// Notes on behaviour
// - select 0 orients in present direction
// - select 1 always approaches forward, reversing first
// - select 2 always approaches reverse, reversing first
// - command ramps to orient speed, latches stop
// - stop value from source and width selects
// - at orient speed wait index, enter position
// - remaining distance, ratio-limited decel, then lock
// - complete output inside in-position zone
// - stop position offset by shift value
// - command dropped with start: accelerate to command
// - start off first; command drop ends orientation
// - pid disabled while orienting
// - no encoder while slowing, waiting index or positioning trips loss fault
// - lag gain zero means PI control
// - deceleration ratio resets to 20
// - orientation speed resets to 2 Hz
// - display 19 shows position pulse monitor
module soc_orient #(
  parameter RAMP_CYC = `SOC_RAMP_CYC,
  parameter ENC_LOSS_CYC = `SOC_ENC_LOSS_CYC
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire orient_command_i,
  input wire forward_start_in_i,
  input wire reverse_start_in_i,
  input wire enc_a_i,
  input wire enc_b_i,
  input wire enc_z_i,
  input wire [15:0] stop_pos_ext_i,
  input wire [15:0] volt_mon_i,
  output reg signed [15:0] freq_cmd_o,
  output reg orient_complete_out_o,
  output reg encoder_loss_fault_o,
  output reg pid_enable_o,
  output reg pos_mode_o,
  output reg [15:0] monitor_o,
  output reg irq_o
);
  localparam ST_RUN = 3'h0;
  localparam ST_SLOW = 3'h1;
  localparam ST_WAITZ = 3'h2;
  localparam ST_POS = 3'h3;
  localparam ST_LOCK = 3'h4;
  localparam ST_FAULT = 3'h5;
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [2:0] s3_r;
  reg [2:0] pin_r;
  reg [2:0] pin_nxt;
  reg [1:0] dirsel_r;
  reg [15:0] ospeed_r;
  reg [15:0] stoppos_r;
  reg [1:0] srcsel_r;
  reg [7:0] pgain_r;
  reg [15:0] decel_r;
  reg [15:0] zone_r;
  reg [15:0] shift_r;
  reg [7:0] laggain_r;
  reg [7:0] disp_r;
  reg [15:0] spdcmd_r;
  reg [2:0] intstat_r;
  reg [2:0] intmask_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg rev_r;
  reg [15:0] tgt_r;
  reg [15:0] rem_r;
  reg signed [15:0] err_prev_r;
  reg signed [31:0] integ_r;
  reg [31:0] ramp_cnt_r;
  reg tick_r;
  reg [31:0] loss_cnt_r;
  reg done_prev_r;
  wire [15:0] pos;
  wire z_pulse;
  wire enc_edge;
  wire cmd;
  wire fwd;
  wire rev;
  wire cmd_rise;
  wire wr;
  wire rd_sel;
  wire signed [15:0] err;
  wire [15:0] err_abs;
  wire in_zone;
  wire [15:0] src_val;
  wire signed [31:0] law;
  wire signed [15:0] law_sat;
  wire signed [15:0] run_tgt;
  wire signed [15:0] slow_tgt;
  wire orienting;
  wire loss;
  wire [2:0] ev;
  //////////////////////////////////////////////////////////////////////
  // encoder counter
  soc_quad u_quad (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .enc_a_i(enc_a_i),
    .enc_b_i(enc_b_i),
    .enc_z_i(enc_z_i),
    .pos_o(pos),
    .z_pulse_o(z_pulse),
    .edge_o(enc_edge)
  );
  //////////////////////////////////////////////////////////////////////
  // command and start pins, three stages each
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          pin_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= (g == 0) ? orient_command_i :
                     (g == 1) ? forward_start_in_i : reverse_start_in_i;
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          pin_r[g] <= pin_nxt[g];
        end
      end
      always @* begin
        pin_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : pin_r[g];
      end
    end
  endgenerate
  assign cmd = pin_nxt[0];
  assign fwd = pin_nxt[1];
  assign rev = pin_nxt[2];
  assign cmd_rise = pin_nxt[0] && !pin_r[0];
  //////////////////////////////////////////////////////////////////////
  // stop target and control law
  assign src_val = srcsel_r[`SOC_SRC_EXT] ? stop_pos_ext_i : stoppos_r;
  assign err = $signed(tgt_r - pos);
  assign err_abs = err[15] ? (16'h0000 - err) : err;
  assign in_zone = (err_abs <= zone_r);
  assign law = (laggain_r == 8'h00) ?
    (err * $signed({1'b0, pgain_r}) + (integ_r >>> 8)) :
    (err * $signed({1'b0, pgain_r}) +
     (err - err_prev_r) * $signed({1'b0, laggain_r}));
  assign law_sat = (law > $signed({16'h0000, ospeed_r})) ? ospeed_r :
    (law < -$signed({16'h0000, ospeed_r})) ? (16'h0000 - ospeed_r) :
    law[15:0];
  assign run_tgt = fwd ? spdcmd_r : rev ? (16'h0000 - spdcmd_r) :
    16'h0000;
  assign slow_tgt = rev_r ? (16'h0000 - ospeed_r) : ospeed_r;
  assign orienting = (st_r != ST_RUN) && (st_r != ST_FAULT);
  assign loss = (loss_cnt_r >= ENC_LOSS_CYC);

  function signed [15:0] soc_step;
    input signed [15:0] cur;
    input signed [15:0] goal;
    input [15:0] step;
    reg signed [16:0] d;
    begin
      d = {goal[15], goal} - {cur[15], cur};
      if (d > $signed({1'b0, step})) begin
        soc_step = cur + step;
      end else if (d < -$signed({1'b0, step})) begin
        soc_step = cur - step;
      end else begin
        soc_step = goal;
      end
    end
  endfunction
  //////////////////////////////////////////////////////////////////////
  // ramp divider
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ramp_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (ramp_cnt_r >= RAMP_CYC - 1) begin
      ramp_cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      ramp_cnt_r <= ramp_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // sequencer
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (cmd_rise) begin
          st_nxt = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (freq_cmd_o == slow_tgt) begin
          st_nxt = ST_WAITZ;
        end
      end
      ST_WAITZ: begin
        if (z_pulse) begin
          st_nxt = ST_POS;
        end
      end
      ST_POS: begin
        if (in_zone) begin
          st_nxt = ST_LOCK;
        end
      end
      ST_LOCK: st_nxt = ST_LOCK;
      ST_FAULT: begin
        if (wr && paddr == `SOC_OFF_CTRL && pwdata[`SOC_CTRL_FCLR]) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
    if (orienting && !cmd) begin
      st_nxt = ST_RUN;
    end
    if (orienting && cmd && loss) begin
      st_nxt = ST_FAULT;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= ST_RUN;
      rev_r <= 1'b0;
      tgt_r <= 16'h0000;
      rem_r <= 16'h0000;
      err_prev_r <= 16'sh0000;
      integ_r <= 32'sh00000000;
      freq_cmd_o <= 16'sh0000;
      loss_cnt_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_RUN && cmd_rise) begin
        tgt_r <= (srcsel_r[`SOC_SRC_16B] ? src_val :
                  {4'h0, src_val[11:0]}) + shift_r;
        case (dirsel_r)
          2'h1: rev_r <= 1'b0;
          2'h2: rev_r <= 1'b1;
          default: rev_r <= freq_cmd_o[15];
        endcase
      end
      if (st_r == ST_WAITZ && z_pulse) begin
        rem_r <= err_abs;
        integ_r <= 32'sh00000000;
      end
      if ((st_r == ST_POS || st_r == ST_LOCK) && tick_r) begin
        err_prev_r <= err;
        if (laggain_r == 8'h00) begin
          integ_r <= integ_r + err;
        end
      end
      if (st_r == ST_SLOW || st_r == ST_WAITZ ||
          (st_r == ST_POS && !enc_edge)) begin
        loss_cnt_r <= loss ? loss_cnt_r : loss_cnt_r + 32'h00000001;
      end else begin
        loss_cnt_r <= 32'h00000000;
      end
      if (enc_edge) begin
        loss_cnt_r <= 32'h00000000;
      end
      if (st_r == ST_FAULT) begin
        freq_cmd_o <= 16'sh0000;
      end else if (tick_r) begin
        case (st_r)
          ST_SLOW, ST_WAITZ: begin
            freq_cmd_o <= soc_step(freq_cmd_o, slow_tgt,
                                   16'h0001);
          end
          ST_POS, ST_LOCK: begin
            freq_cmd_o <= soc_step(freq_cmd_o, law_sat, decel_r);
          end
          default: begin
            freq_cmd_o <= soc_step(freq_cmd_o, run_tgt, 16'h0001);
          end
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // status outputs
  assign ev[`SOC_INT_DONE] = (st_r == ST_LOCK) && in_zone && !done_prev_r;
  assign ev[`SOC_INT_FAULT] = (st_nxt == ST_FAULT) && (st_r != ST_FAULT);
  assign ev[`SOC_INT_ZIDX] = z_pulse;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      orient_complete_out_o <= 1'b0;
      encoder_loss_fault_o <= 1'b0;
      pid_enable_o <= 1'b1;
      pos_mode_o <= 1'b0;
      monitor_o <= 16'h0000;
      irq_o <= 1'b0;
      done_prev_r <= 1'b0;
    end else begin
      done_prev_r <= (st_r == ST_LOCK) && in_zone;
      orient_complete_out_o <= (st_nxt == ST_LOCK) && in_zone;
      encoder_loss_fault_o <= (st_nxt == ST_FAULT);
      pid_enable_o <= !(st_nxt != ST_RUN && st_nxt != ST_FAULT);
      pos_mode_o <= (st_nxt == ST_POS) || (st_nxt == ST_LOCK);
      monitor_o <= (disp_r == `SOC_DISP_POS) ? pos : volt_mon_i;
      irq_o <= |(intstat_r & intmask_r);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access cycle after setup
  assign wr = psel && penable && pready && pwrite;
  assign rd_sel = psel && !penable;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      dirsel_r <= `SOC_RST_DIRSEL;
      ospeed_r <= `SOC_RST_OSPEED;
      stoppos_r <= 16'h0000;
      srcsel_r <= 2'h0;
      pgain_r <= `SOC_RST_PGAIN;
      decel_r <= `SOC_RST_DECEL;
      zone_r <= `SOC_RST_ZONE;
      shift_r <= 16'h0000;
      laggain_r <= 8'h00;
      disp_r <= `SOC_RST_DISP;
      spdcmd_r <= 16'h0000;
      intstat_r <= 3'h0;
      intmask_r <= 3'h0;
    end else begin
      pready <= rd_sel;
      if (rd_sel) begin
        pslverr <= (paddr[1:0] != 2'h0) || (paddr > `SOC_OFF_POS);
        case (paddr)
          `SOC_OFF_DIRSEL: prdata <= {30'h0, dirsel_r};
          `SOC_OFF_OSPEED: prdata <= {16'h0, ospeed_r};
          `SOC_OFF_STOPPOS: prdata <= {16'h0, stoppos_r};
          `SOC_OFF_SRCSEL: prdata <= {30'h0, srcsel_r};
          `SOC_OFF_PGAIN: prdata <= {24'h0, pgain_r};
          `SOC_OFF_DECEL: prdata <= {16'h0, decel_r};
          `SOC_OFF_ZONE: prdata <= {16'h0, zone_r};
          `SOC_OFF_SHIFT: prdata <= {16'h0, shift_r};
          `SOC_OFF_LAGGAIN: prdata <= {24'h0, laggain_r};
          `SOC_OFF_DISP: prdata <= {24'h0, disp_r};
          `SOC_OFF_SPDCMD: prdata <= {16'h0, spdcmd_r};
          `SOC_OFF_STATUS: prdata <= {rem_r, tgt_r[7:0],
            encoder_loss_fault_o, orient_complete_out_o, rev_r,
            !pid_enable_o, 1'b0, st_r};
          `SOC_OFF_INTSTAT: prdata <= {29'h0, intstat_r};
          `SOC_OFF_INTMASK: prdata <= {29'h0, intmask_r};
          `SOC_OFF_POS: prdata <= {16'h0, pos};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (wr && !pslverr) begin
        case (paddr)
          `SOC_OFF_DIRSEL: dirsel_r <= pwdata[1:0];
          `SOC_OFF_OSPEED: ospeed_r <= pwdata[15:0];
          `SOC_OFF_STOPPOS: stoppos_r <= pwdata[15:0];
          `SOC_OFF_SRCSEL: srcsel_r <= pwdata[1:0];
          `SOC_OFF_PGAIN: pgain_r <= pwdata[7:0];
          `SOC_OFF_DECEL: decel_r <= pwdata[15:0];
          `SOC_OFF_ZONE: zone_r <= pwdata[15:0];
          `SOC_OFF_SHIFT: shift_r <= pwdata[15:0];
          `SOC_OFF_LAGGAIN: laggain_r <= pwdata[7:0];
          `SOC_OFF_DISP: disp_r <= pwdata[7:0];
          `SOC_OFF_SPDCMD: spdcmd_r <= pwdata[15:0];
          `SOC_OFF_INTMASK: intmask_r <= pwdata[2:0];
          default: ;
        endcase
      end
      if (wr && !pslverr && paddr == `SOC_OFF_INTSTAT) begin
        intstat_r <= (intstat_r & ~pwdata[2:0]) | ev;
      end else begin
        intstat_r <= intstat_r | ev;
      end
    end
  end
endmodule // soc_orient

//--- sim/soc_orient_props.sv
// assertions on the ports of the orientation sequencer
// assumes binding to soc_orient, one clock, sync active-low reset
`timescale 1ns/10ps
module soc_orient_props (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire orient_command_i,
  input wire orient_complete_out_o,
  input wire encoder_loss_fault_o,
  input wire pid_enable_o,
  input wire pos_mode_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_bad_addr: assert property (psel && !penable &&
    (paddr > 8'h3C || paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  a_err_good_addr: assert property (psel && !penable &&
    paddr <= 8'h3C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("good address refused");
  a_pid_off_pos: assert property (pos_mode_o |-> !pid_enable_o)
    else $error("pid active in position mode");
  a_done_in_pos: assert property (orient_complete_out_o |->
    pos_mode_o && !encoder_loss_fault_o)
    else $error("complete outside position hold");
  a_cmd_low_ends: assert property (!orient_command_i [*8] |->
    pid_enable_o && !pos_mode_o && !orient_complete_out_o)
    else $error("orientation kept without command");
  a_fault_stops: assert property (encoder_loss_fault_o |->
    pid_enable_o && !pos_mode_o)
    else $error("fault state still orienting");
  a_cmd_starts: assert property ($rose(orient_command_i) &&
    pid_enable_o && !encoder_loss_fault_o |-> ##[1:8] !pid_enable_o)
    else $error("command rise ignored");
endmodule // soc_orient_props

//--- sim/soc_motor_enc.sv
// motor with quadrature encoder, speed follows the frequency command
// assumes freq_i signed in 0.01 Hz units, same clock as the block
`timescale 1ns/10ps
module soc_motor_enc #(
  parameter int STEP = 400,
  parameter int PPR = 64
) (
  input wire logic ref_clk_i,
  input wire logic cut_i,
  input wire logic signed [15:0] freq_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_z_o
);
  int acc = 0;
  int cnt = 0;
  int spd;
  //////////////////////////////////////////////////////////////////////////
  // one count per STEP of speed; cut cable stops counting
  assign spd = (freq_i < 0) ? -freq_i : freq_i;
  always @(posedge ref_clk_i) begin
    if (cut_i) begin
      acc <= 0;
    end else if (acc + spd >= STEP) begin
      acc <= 0;
      cnt <= (cnt + (freq_i < 0 ? PPR - 1 : 1)) % PPR;
    end else begin
      acc <= acc + spd;
    end
  end
  // a leads b forward, one index per turn; cut lines float inverted
  assign enc_a_o = cnt[1] ^ cnt[0] ^ cut_i;
  assign enc_b_o = cnt[1] ^ cut_i;
  assign enc_z_o = (cnt == 0) ^ cut_i;
endmodule // soc_motor_enc

//--- sim/soc_orient_tb.sv
// self-checking bench for the orientation sequencer
// assumes soc_orient, the motor model and the bound checker
`timescale 1ns/10ps
`include "soc_orient_regs.vh"
module soc_orient_tb;
  logic ref_clk_i = 0;
  logic rst_n_i = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr;
  logic cmd = 0, fwd_st = 0, rev_st = 0, cut = 0;
  logic [15:0] ext_pos = 16'hF018;
  logic [15:0] volt = 16'h1234;
  logic [15:0] mon;
  logic signed [15:0] freq;
  logic done, fault, pid, pmode, irq, ea, eb, ez;
  int n_errors = 0;
  int checked = 0;
  logic [7:0] roff [6] = '{`SOC_OFF_DIRSEL, `SOC_OFF_OSPEED,
    `SOC_OFF_PGAIN, `SOC_OFF_DECEL, `SOC_OFF_ZONE, `SOC_OFF_DISP};
  logic [31:0] rval [6] = '{32'h0, 32'hC8, 32'h0A, 32'h14, 32'h0B, 32'h0};
  logic [3:0] tab [6] = '{4'h8, 4'h1, 4'hA, 4'h2, 4'hD, 4'h5};
  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  soc_orient #(.RAMP_CYC(2), .ENC_LOSS_CYC(2000)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .orient_command_i(cmd), .forward_start_in_i(fwd_st),
    .reverse_start_in_i(rev_st), .enc_a_i(ea), .enc_b_i(eb),
    .enc_z_i(ez), .stop_pos_ext_i(ext_pos), .volt_mon_i(volt),
    .freq_cmd_o(freq), .orient_complete_out_o(done),
    .encoder_loss_fault_o(fault), .pid_enable_o(pid),
    .pos_mode_o(pmode), .monitor_o(mon), .irq_o(irq));
  soc_motor_enc #(.STEP(400), .PPR(64)) motor (
    .ref_clk_i(ref_clk_i), .cut_i(cut), .freq_i(freq),
    .enc_a_o(ea), .enc_b_o(eb), .enc_z_o(ez));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  // setup, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    check("pready", pready, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("outputs", {pid, pmode, done, fault, irq}, 5'h10);
    check("freq", freq, 16'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, roff[i], 32'h0);
      check("reset value", rdat, rval[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", rerr, 1'b1);
    check("unmapped data", rdat, 32'h0);
    apb(1'b0, 8'h06, 32'h0);
    check("unaligned", rerr, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_monitor;
    check("mon volt", mon, 16'h1234);
    apb(1'b1, `SOC_OFF_DISP, 32'h13);
    cyc(2);
    check("mon pos", mon, 16'h0000);
    apb(1'b1, `SOC_OFF_DISP, 32'h00);
    cyc(2);
    check("mon back", mon, 16'h1234);
    $display("monitor test done");
  endtask
  task automatic t_orient(input logic fs, input logic [1:0] ds,
                          input logic ext, input logic er);
    int n;
    logic signed [15:0] sp;
    logic signed [15:0] os;
    sp = fs ? 16'sh28 : -16'sh28;
    os = er ? -16'sh0A : 16'sh0A;
    apb(1'b1, `SOC_OFF_DIRSEL, {30'h0, ds});
    apb(1'b1, `SOC_OFF_SRCSEL, ext ? 32'h1 : 32'h2);
    fwd_st <= fs;
    rev_st <= !fs;
    for (n = 0; n < 3000 && freq !== sp; n++) cyc(1);
    cmd <= 1'b1;
    for (n = 0; n < 3000 && freq !== os; n++) cyc(1);
    check("orient speed", freq, os);
    check("pid off", pid, 1'b0);
    apb(1'b0, `SOC_OFF_STATUS, 32'h0);
    check("direction", rdat[5], er);
    check("target", rdat[15:8], 8'h20);
    if (!er) begin
      for (n = 0; n < 30000 && done !== 1'b1; n++) cyc(1);
      check("complete", {done, pmode}, 2'h3);
      apb(1'b0, `SOC_OFF_POS, 32'h0);
      check("in zone", rdat[15:0] >= 16'h15 && rdat[15:0] <= 16'h2B,
        1'b1);
      apb(1'b0, `SOC_OFF_INTSTAT, 32'h0);
      check("done flag", {rdat[0], irq}, 2'h3);
      apb(1'b1, `SOC_OFF_INTSTAT, 32'h7);
    end
    fwd_st <= 1'b0;
    rev_st <= 1'b0;
    cyc(10);
    cmd <= 1'b0;
    cyc(10);
    check("ended", {pid, pmode, done}, 3'h4);
    $display("orient run done");
  endtask
  task automatic t_fault;
    int n;
    cut <= 1'b1;
    fwd_st <= 1'b1;
    apb(1'b1, `SOC_OFF_INTMASK, 32'h2);
    cmd <= 1'b1;
    for (n = 0; n < 5000 && fault !== 1'b1; n++) cyc(1);
    check("fault", fault, 1'b1);
    cyc(2);
    check("irq on", irq, 1'b1);
    apb(1'b1, `SOC_OFF_INTMASK, 32'h0);
    cyc(2);
    check("irq masked", irq, 1'b0);
    cmd <= 1'b0;
    cyc(10);
    apb(1'b1, `SOC_OFF_CTRL, 32'h1);
    apb(1'b1, `SOC_OFF_INTSTAT, 32'h2);
    apb(1'b0, `SOC_OFF_INTSTAT, 32'h0);
    check("fault clear", {fault, rdat[1]}, 2'h0);
    cut <= 1'b0;
    for (n = 0; n < 3000 && freq !== 16'sh28; n++) cyc(1);
    check("resume speed", freq, 16'sh28);
    fwd_st <= 1'b0;
    $display("fault test done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_monitor;
    apb(1'b1, `SOC_OFF_SPDCMD, 32'h28);
    apb(1'b1, `SOC_OFF_OSPEED, 32'h0A);
    apb(1'b1, `SOC_OFF_SHIFT, 32'h08);
    apb(1'b1, `SOC_OFF_STOPPOS, 32'h18);
    apb(1'b1, `SOC_OFF_LAGGAIN, 32'h00);
    apb(1'b1, `SOC_OFF_INTMASK, 32'h01);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `SOC_OFF_LAGGAIN, (i == 2) ? 32'h4 : 32'h0);
      t_orient(tab[i][3], tab[i][2:1], i[0], tab[i][0]);
    end
    t_fault;
    results;
  end
  initial begin
    repeat (95000) @(posedge ref_clk_i);
    n_errors++;
    results;
  end
endmodule // soc_orient_tb
bind soc_orient soc_orient_props props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .orient_command_i(orient_command_i),
  .orient_complete_out_o(orient_complete_out_o),
  .encoder_loss_fault_o(encoder_loss_fault_o),
  .pid_enable_o(pid_enable_o), .pos_mode_o(pos_mode_o));
